// ===== rtl/fsag_params.svh
/*
 flash security access guard constants: lock byte addresses, block geometry,
 partition limit layout, reset values. assumes 17-bit flash byte addresses.
*/
`ifndef FSAG_PARAMS_SVH
`define FSAG_PARAMS_SVH

`define FSAG_ADDR_W          17
`define FSAG_READ_LOCK_ADDR  17'h1fbff
`define FSAG_WRITE_LOCK_ADDR 17'h1fbfe
`define FSAG_LOCK_PAGE_BASE  17'h1f800
`define FSAG_LOCK_PAGE_TOP   17'h1fbff
`define FSAG_PAGE_LSB        10
`define FSAG_BLOCK_LSB       14
`define FSAG_BLOCK_TOP_BIT   7
`define FSAG_LIMIT_LSB       9
`define FSAG_LIMIT_LOW_ZERO  9'h000
`define FSAG_LOCK_OPEN       8'hff
`define FSAG_LIMIT_RESET     8'h00
`define FSAG_READ_JUNK       8'hff
`define FSAG_SCRATCH_LOCKED  8'h00

`endif

// ===== rtl/fsag_pkg.sv
/*
 types for the flash security access guard.
 assumes the constants header is included by every user.
*/
package fsag_pkg;
    typedef enum logic [1:0] {
        FSAG_JT_READ  = 2'h0,
        FSAG_JT_WRITE = 2'h1,
        FSAG_JT_ERASE = 2'h3
    } fsag_jtag_op_t;

    typedef enum logic [1:0] {
        FSAG_ER_NONE  = 2'h0,
        FSAG_ER_PAGE  = 2'h1,
        FSAG_ER_FULL  = 2'h3
    } fsag_erase_kind_t;
endpackage : fsag_pkg

// ===== rtl/fsag_lock_decode.sv
/*
 combinational lock lookup: maps an address to its 16 kB block and reports
 whether the read and write/erase locks hold it. assumes lock bytes are valid.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fsag_params.svh"

module fsag_lock_decode (
    // address and target
    input  wire logic [16:0] addr_i,
    input  wire logic        scratch_i,
    // lock bytes
    input  wire logic [7:0]  read_lock_i,
    input  wire logic [7:0]  write_lock_i,
    // verdict
    output logic             read_locked_o,
    output logic             write_locked_o
);
    function automatic logic lock_hit(input logic [7:0] lb, input logic [16:0] a,
                                      input logic sc);
        logic [2:0] blk;
        blk = a[`FSAG_ADDR_W-1:`FSAG_BLOCK_LSB];
        if (sc) begin
            lock_hit = (lb == `FSAG_SCRATCH_LOCKED);
        end else begin
            lock_hit = ~lb[blk];
        end
    endfunction : lock_hit

    always_comb begin
        read_locked_o  = lock_hit(read_lock_i, addr_i, scratch_i);
        write_locked_o = lock_hit(write_lock_i, addr_i, scratch_i);
    end
endmodule : fsag_lock_decode

`default_nettype wire

// ===== rtl/fsag_limit_check.sv
/*
 software partition check: compares the issuing instruction address and the
 target against the limit address. assumes limit byte already registered.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fsag_params.svh"

module fsag_limit_check (
    // addresses
    input  wire logic [7:0]  limit_i,
    input  wire logic [16:0] pc_i,
    input  wire logic [16:0] target_i,
    // verdict
    output logic [16:0]      limit_addr_o,
    output logic             blocked_o
);
    always_comb begin
        limit_addr_o = {limit_i, `FSAG_LIMIT_LOW_ZERO};
        // upper code may not touch lower data; lower code is free
        blocked_o = (pc_i >= limit_addr_o) && (target_i < limit_addr_o);
    end
endmodule : fsag_limit_check

`default_nettype wire

// ===== rtl/fsag_guard.sv
/*
 flash security access guard: gates software and jtag flash requests by the
 enable bits, lock bytes and the write-once limit. assumes a flash engine that
 performs granted operations and returns read data one cycle after request.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fsag_params.svh"

// Operation
// - software write needs write and modify enables; erase also erase enable
// - read lock byte at 0x1fbff, write/erase lock byte at 0x1fbfe
// - each lock bit guards one 16 kB block, bit 0 lowest
// - read lock bit zero denies jtag reads of that block
// - write lock bit zero denies jtag writes and erases of that block
// - jtag read of a read-locked location returns junk, debug barred
// - scratchpad counts locked only when every block is locked
// - software may program the lock page but never erase it
// - top block write-locked: security bytes programmable, not erasable
// - lock bits are always readable and clearable to zero
// - no firmware path sets a lock bit; only jtag erase removes locks
// - jtag erase at a security byte erases all program memory
// - jtag erase elsewhere in lock page erases only that page
// - limit address is limit byte over nine zero bits
// - upper code may not read, write or erase below limit; reads junk
// - upper code may still execute lower partition code
// - code below the limit has unrestricted access
// - limit register takes only the first write after reset
// - limit resets to zero so all memory readable
// - page erase needs erase and write enable plus a store to that page
module fsag_guard (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // control bits from software
    input  wire logic        store_write_enable_i,
    input  wire logic        store_erase_enable_i,
    input  wire logic        flash_modify_enable_i,
    // limit register write port
    input  wire logic        limit_wr_i,
    input  wire logic [7:0]  limit_wdata_i,
    // lock bytes as currently held in flash
    input  wire logic [7:0]  read_lock_byte_i,
    input  wire logic [7:0]  write_lock_byte_i,
    // software access from the core
    input  wire logic        sw_req_i,
    input  wire logic        sw_store_i,
    input  wire logic        sw_fetch_i,
    input  wire logic        sw_scratch_i,
    input  wire logic [16:0] sw_pc_i,
    input  wire logic [16:0] sw_addr_i,
    // jtag access
    input  wire logic        jt_req_i,
    input  wire logic [1:0]  jt_op_i,
    input  wire logic [16:0] jt_addr_i,
    // flash read data
    input  wire logic [7:0]  flash_rdata_i,
    // results
    output logic [7:0]       limit_o,
    output logic [16:0]      limit_addr_o,
    output logic             sw_grant_o,
    output logic             sw_deny_o,
    output logic             sw_write_o,
    output logic             sw_erase_o,
    output logic [7:0]       sw_rdata_o,
    output logic             jt_grant_o,
    output logic             jt_deny_o,
    output logic [1:0]       jt_erase_kind_o,
    output logic [7:0]       jt_rdata_o,
    output logic             debug_blocked_o
);
    typedef struct packed {
        logic [7:0]  limit;
        logic        limit_taken;
        logic [16:0] limit_addr;
        logic        sw_grant;
        logic        sw_deny;
        logic        sw_write;
        logic        sw_erase;
        logic        sw_rd_pend;
        logic        sw_rd_junk;
        logic        jt_grant;
        logic        jt_deny;
        logic [1:0]  jt_erase_kind;
        logic        jt_rd_pend;
        logic        jt_rd_junk;
        logic        debug_blocked;
        logic [7:0]  sw_rdata;
        logic [7:0]  jt_rdata;
    } fsag_state_t;

    fsag_state_t st_reg;
    fsag_state_t st_next;

    logic [16:0] lim_addr;
    logic        part_blocked;
    logic        jt_rlocked;
    logic        jt_wlocked;
    logic        pc_rlocked;

    fsag_limit_check u_limit (
        .limit_i      (st_reg.limit),
        .pc_i         (sw_pc_i),
        .target_i     (sw_addr_i),
        .limit_addr_o (lim_addr),
        .blocked_o    (part_blocked)
    );

    fsag_lock_decode u_jt_lock (
        .addr_i         (jt_addr_i),
        .scratch_i      (1'b0),
        .read_lock_i    (read_lock_byte_i),
        .write_lock_i   (write_lock_byte_i),
        .read_locked_o  (jt_rlocked),
        .write_locked_o (jt_wlocked)
    );

    // scratchpad view: locked only when every block is read-locked
    fsag_lock_decode u_pc_lock (
        .addr_i         (jt_addr_i),
        .scratch_i      (1'b1),
        .read_lock_i    (read_lock_byte_i),
        .write_lock_i   (write_lock_byte_i),
        .read_locked_o  (pc_rlocked),
        .write_locked_o ()
    );

    function automatic logic is_sec_byte(input logic [16:0] a);
        is_sec_byte = (a == `FSAG_READ_LOCK_ADDR) || (a == `FSAG_WRITE_LOCK_ADDR);
    endfunction : is_sec_byte

    function automatic logic in_lock_page(input logic [16:0] a);
        in_lock_page = (a[`FSAG_ADDR_W-1:`FSAG_PAGE_LSB] ==
                        7'(`FSAG_LOCK_PAGE_BASE >> `FSAG_PAGE_LSB));
    endfunction : in_lock_page

    always_comb begin
        logic sw_modify;
        logic sw_erase_req;
        logic sw_ok;
        logic jt_sec;
        logic jt_ok;
        logic top_locked;
        st_next       = st_reg;
        sw_modify     = 1'b0;
        sw_erase_req  = 1'b0;
        sw_ok         = 1'b0;
        jt_sec        = 1'b0;
        jt_ok         = 1'b0;
        top_locked    = ~write_lock_byte_i[`FSAG_BLOCK_TOP_BIT];

        // write-once limit
        if (limit_wr_i && !st_reg.limit_taken) begin
            st_next.limit       = limit_wdata_i;
            st_next.limit_taken = 1'b1;
        end
        st_next.limit_addr = lim_addr;

        // software access
        st_next.sw_grant   = 1'b0;
        st_next.sw_deny    = 1'b0;
        st_next.sw_write   = 1'b0;
        st_next.sw_erase   = 1'b0;
        st_next.sw_rd_pend = 1'b0;
        if (sw_req_i) begin
            if (sw_fetch_i) begin
                // instruction fetch is never partition-gated
                sw_ok = 1'b1;
                st_next.sw_rd_pend = 1'b1;
                st_next.sw_rd_junk = 1'b0;
            end else if (sw_store_i) begin
                sw_modify    = store_write_enable_i && flash_modify_enable_i;
                sw_erase_req = store_erase_enable_i;
                if (sw_erase_req) begin
                    // data value is irrelevant; whole page goes
                    sw_ok = sw_modify && !part_blocked
                            && !(in_lock_page(sw_addr_i) && !sw_scratch_i);
                    st_next.sw_erase = sw_ok;
                end else begin
                    // programming may only clear bits, so lock bytes stay clearable
                    sw_ok = sw_modify && !part_blocked;
                    st_next.sw_write = sw_ok;
                end
            end else begin
                sw_ok = 1'b1;
                st_next.sw_rd_pend = 1'b1;
                st_next.sw_rd_junk = part_blocked && !is_sec_byte(sw_addr_i);
            end
            st_next.sw_grant = sw_ok;
            st_next.sw_deny  = !sw_ok;
        end
        if (st_reg.sw_rd_pend) begin
            st_next.sw_rdata = st_reg.sw_rd_junk ? `FSAG_READ_JUNK : flash_rdata_i;
        end

        // jtag access
        st_next.jt_grant      = 1'b0;
        st_next.jt_deny       = 1'b0;
        st_next.jt_erase_kind = fsag_pkg::FSAG_ER_NONE;
        st_next.jt_rd_pend    = 1'b0;
        if (jt_req_i) begin
            jt_sec = is_sec_byte(jt_addr_i);
            unique case (jt_op_i)
                fsag_pkg::FSAG_JT_READ: begin
                    jt_ok = 1'b1;
                    st_next.jt_rd_pend = 1'b1;
                    st_next.jt_rd_junk = jt_rlocked && !jt_sec;
                end
                fsag_pkg::FSAG_JT_WRITE: begin
                    // lock bytes may always be programmed towards zero
                    jt_ok = !jt_wlocked || jt_sec;
                end
                fsag_pkg::FSAG_JT_ERASE: begin
                    if (jt_sec) begin
                        jt_ok = 1'b1;
                        st_next.jt_erase_kind = fsag_pkg::FSAG_ER_FULL;
                    end else if (in_lock_page(jt_addr_i)) begin
                        // lock page erase would reopen every lock, so top lock bars it
                        jt_ok = !(top_locked);
                        if (jt_ok) begin
                            st_next.jt_erase_kind = fsag_pkg::FSAG_ER_PAGE;
                        end
                    end else begin
                        jt_ok = !jt_wlocked;
                        if (jt_ok) begin
                            st_next.jt_erase_kind = fsag_pkg::FSAG_ER_PAGE;
                        end
                    end
                end
                default: begin
                    jt_ok = 1'b0;
                end
            endcase
            st_next.jt_grant = jt_ok;
            st_next.jt_deny  = !jt_ok;
        end
        if (st_reg.jt_rd_pend) begin
            st_next.jt_rdata = st_reg.jt_rd_junk ? `FSAG_READ_JUNK : flash_rdata_i;
        end
        // debugging read-locked code is barred while any block is read-locked
        st_next.debug_blocked = (read_lock_byte_i != `FSAG_LOCK_OPEN) || pc_rlocked;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            // pulses idle, read data parked at the junk value
            st_reg.limit         <= `FSAG_LIMIT_RESET;
            st_reg.limit_taken   <= 1'b0;
            st_reg.limit_addr    <= {`FSAG_LIMIT_RESET, `FSAG_LIMIT_LOW_ZERO};
            st_reg.sw_grant      <= 1'b0;
            st_reg.sw_deny       <= 1'b0;
            st_reg.sw_write      <= 1'b0;
            st_reg.sw_erase      <= 1'b0;
            st_reg.sw_rd_pend    <= 1'b0;
            st_reg.sw_rd_junk    <= 1'b0;
            st_reg.jt_grant      <= 1'b0;
            st_reg.jt_deny       <= 1'b0;
            st_reg.jt_erase_kind <= fsag_pkg::FSAG_ER_NONE;
            st_reg.jt_rd_pend    <= 1'b0;
            st_reg.jt_rd_junk    <= 1'b0;
            st_reg.debug_blocked <= 1'b0;
            st_reg.sw_rdata      <= `FSAG_READ_JUNK;
            st_reg.jt_rdata      <= `FSAG_READ_JUNK;
        end else begin
            st_reg <= st_next;
        end
    end

    assign limit_o         = st_reg.limit;
    assign limit_addr_o    = st_reg.limit_addr;
    assign sw_grant_o      = st_reg.sw_grant;
    assign sw_deny_o       = st_reg.sw_deny;
    assign sw_write_o      = st_reg.sw_write;
    assign sw_erase_o      = st_reg.sw_erase;
    assign sw_rdata_o      = st_reg.sw_rdata;
    assign jt_grant_o      = st_reg.jt_grant;
    assign jt_deny_o       = st_reg.jt_deny;
    assign jt_erase_kind_o = st_reg.jt_erase_kind;
    assign jt_rdata_o      = st_reg.jt_rdata;
    assign debug_blocked_o = st_reg.debug_blocked;
endmodule : fsag_guard

`default_nettype wire

// ===== tb/fsag_guard_monitor.sv
/* port checker for fsag_guard.
   assumes it is bound to every fsag_guard instance. */
`timescale 1ns/1ps
`default_nettype none
module fsag_guard_monitor (
    // clock and inputs
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    input wire logic        store_write_enable_i,
    input wire logic        store_erase_enable_i,
    input wire logic        flash_modify_enable_i,
    input wire logic        limit_wr_i,
    input wire logic [7:0]  read_lock_byte_i,
    input wire logic [7:0]  write_lock_byte_i,
    input wire logic        sw_req_i,
    input wire logic        sw_store_i,
    input wire logic        sw_fetch_i,
    input wire logic        sw_scratch_i,
    input wire logic [16:0] sw_pc_i,
    input wire logic [16:0] sw_addr_i,
    input wire logic        jt_req_i,
    input wire logic [1:0]  jt_op_i,
    input wire logic [16:0] jt_addr_i,
    // results
    input wire logic [7:0]  limit_o,
    input wire logic [16:0] limit_addr_o,
    input wire logic        sw_deny_o,
    input wire logic        sw_write_o,
    input wire logic        sw_erase_o,
    input wire logic        jt_grant_o,
    input wire logic        jt_deny_o,
    input wire logic [1:0]  jt_erase_kind_o,
    input wire logic [7:0]  jt_rdata_o
);
    logic             taken_reg;
    wire logic [16:0] lim = {limit_o, 9'h000};
    wire logic        sec = jt_addr_i == 17'h1fbff || jt_addr_i == 17'h1fbfe;
    wire logic        jpg = jt_addr_i >= 17'h1f800 && jt_addr_i <= 17'h1fbff;
    wire logic        spg = sw_addr_i >= 17'h1f800 && sw_addr_i <= 17'h1fbff && !sw_scratch_i;
    // set once the limit has taken its one write
    always_ff @(posedge clk_i) begin
        taken_reg <= rst_n_i && (taken_reg || limit_wr_i);
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    store_enable_a: assert property (sw_write_o |->
        $past(sw_req_i && sw_store_i && store_write_enable_i && flash_modify_enable_i))
        else $error("store without enables");
    lock_page_a: assert property (sw_req_i && sw_store_i && store_erase_enable_i && spg
        && !sw_fetch_i |=> sw_deny_o && !sw_erase_o) else $error("lock page erased");
    upper_store_a: assert property (sw_req_i && sw_store_i && !sw_scratch_i
        && !sw_fetch_i && sw_pc_i >= lim && sw_addr_i < lim |=> sw_deny_o)
        else $error("lower store passed");
    limit_once_a: assert property ($past(taken_reg) |-> $stable(limit_o))
        else $error("limit rewritten");
    limit_shape_a: assert property ($past(rst_n_i) |->
        limit_addr_o == {$past(limit_o), 9'h000}) else $error("limit address wrong");
    limit_reset_a: assert property (!$past(rst_n_i) |->
        limit_o == 8'h00 && limit_addr_o == 17'h00000) else $error("limit not cleared");
    read_lock_a: assert property (jt_req_i && jt_op_i == 2'h0 && !sec
        && !read_lock_byte_i[jt_addr_i[16:14]] |-> ##2 jt_rdata_o == 8'hff)
        else $error("locked read leaked");
    write_lock_a: assert property (jt_req_i && jt_op_i == 2'h1 && !sec
        && !write_lock_byte_i[jt_addr_i[16:14]] |=> jt_deny_o) else $error("locked write");
    full_erase_a: assert property (jt_req_i && jt_op_i == 2'h3 && sec
        |=> jt_grant_o && jt_erase_kind_o == 2'h3) else $error("no full erase");
    page_erase_a: assert property (jt_req_i && jt_op_i == 2'h3 && jpg && !sec
        && write_lock_byte_i[7] |=> jt_erase_kind_o == 2'h1) else $error("no page erase");
    cover property (sw_write_o);
    cover property (jt_erase_kind_o == 2'h3);
    cover property (jt_erase_kind_o == 2'h1);
endmodule : fsag_guard_monitor
bind fsag_guard fsag_guard_monitor u_mon (.clk_i, .rst_n_i, .store_write_enable_i,
    .store_erase_enable_i, .flash_modify_enable_i, .limit_wr_i, .read_lock_byte_i,
    .write_lock_byte_i, .sw_req_i, .sw_store_i, .sw_fetch_i, .sw_scratch_i, .sw_pc_i,
    .sw_addr_i,
    .jt_req_i, .jt_op_i, .jt_addr_i, .limit_o, .limit_addr_o, .sw_deny_o, .sw_write_o,
    .sw_erase_o, .jt_grant_o, .jt_deny_o, .jt_erase_kind_o, .jt_rdata_o);
`default_nettype wire

// ===== tb/fsag_flash_stub.sv
/* flash array stand-in: answers a read the cycle after the request.
   assumes one request per cycle. */
`timescale 1ns/1ps
`default_nettype none
module fsag_flash_stub (
    // requests seen by the guard
    input  wire logic        clk_i,
    input  wire logic        sw_req_i,
    input  wire logic [16:0] sw_addr_i,
    input  wire logic        jt_req_i,
    input  wire logic [16:0] jt_addr_i,
    // read data
    output logic [7:0]       flash_rdata_o
);
    logic [16:0] addr_reg;
    logic        valid_reg;
    logic [7:0]  idle_reg = 8'h00;
    always_ff @(posedge clk_i) begin
        addr_reg <= jt_req_i ? jt_addr_i : sw_addr_i;
        valid_reg <= jt_req_i || sw_req_i;
        idle_reg <= idle_reg + 8'h3b;
    end
    // moving pattern outside the answer cycle, never stale data
    assign flash_rdata_o = valid_reg ? addr_reg[7:0] ^ addr_reg[15:8] : idle_reg;
endmodule : fsag_flash_stub
`default_nettype wire

// ===== tb/fsag_guard_test.sv
/* self-checking bench for fsag_guard with a task-level reference model.
   assumes the flash stub and the bound port checker. */
`timescale 1ns/1ps
`default_nettype none
module fsag_guard_test;
    logic        clk_i = 0, rst_n_i = 0, limit_wr_i = 0, sw_req_i = 0, jt_req_i = 0;
    logic        store_write_enable_i = 0, store_erase_enable_i = 0, flash_modify_enable_i = 0;
    logic        sw_store_i = 0, sw_fetch_i = 0, sw_scratch_i = 0;
    logic [7:0]  limit_wdata_i = 0, read_lock_byte_i = 8'hff, write_lock_byte_i = 8'hff;
    logic [16:0] sw_pc_i = 0, sw_addr_i = 0, jt_addr_i = 0, limit_addr_o, a;
    logic [1:0]  jt_op_i = 0, jt_erase_kind_o;
    logic [7:0]  flash_rdata_i, limit_o, sw_rdata_o, jt_rdata_o, lim_m;
    logic        sw_grant_o, sw_deny_o, sw_write_o, sw_erase_o;
    logic        jt_grant_o, jt_deny_o, debug_blocked_o;
    bit          lim_set, st_r;
    int          n_fail, checks;
    always #4 clk_i = ~clk_i;
    fsag_guard dut (.clk_i, .rst_n_i, .store_write_enable_i, .store_erase_enable_i,
        .flash_modify_enable_i, .limit_wr_i, .limit_wdata_i, .read_lock_byte_i,
        .write_lock_byte_i, .sw_req_i, .sw_store_i, .sw_fetch_i, .sw_scratch_i, .sw_pc_i,
        .sw_addr_i, .jt_req_i, .jt_op_i, .jt_addr_i, .flash_rdata_i, .limit_o, .limit_addr_o,
        .sw_grant_o, .sw_deny_o, .sw_write_o, .sw_erase_o, .sw_rdata_o, .jt_grant_o,
        .jt_deny_o, .jt_erase_kind_o, .jt_rdata_o, .debug_blocked_o);
    fsag_flash_stub u_flash (.clk_i, .sw_req_i, .sw_addr_i, .jt_req_i, .jt_addr_i,
        .flash_rdata_o(flash_rdata_i));
    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : summarize
    task automatic do_reset();
        rst_n_i <= 1'b0;
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'b1;
        lim_m = 8'h00;
        lim_set = 0;
        @(posedge clk_i);
        #1;
        chk(limit_o, 8'h00);
        chk(limit_addr_o, 17'h00000);
        chk(sw_rdata_o, 8'hff);
        chk(jt_rdata_o, 8'hff);
    endtask : do_reset
    task automatic set_lim(input logic [7:0] v);
        @(posedge clk_i);
        limit_wr_i <= 1'b1;
        limit_wdata_i <= v;
        @(posedge clk_i);
        limit_wr_i <= 1'b0;
        if (!lim_set) lim_m = v;
        lim_set = 1;
        repeat (2) @(posedge clk_i);
        #1;
        chk(limit_o, lim_m);
        chk(limit_addr_o, {lim_m, 9'h000});
    endtask : set_lim
    task automatic sw(input logic [16:0] pc, input logic [16:0] ad, input logic st, fe);
        logic bl, ok;
        @(posedge clk_i);
        bl = pc >= {lim_m, 9'h000} && ad < {lim_m, 9'h000};
        ok = store_write_enable_i && flash_modify_enable_i && !bl
            && !(store_erase_enable_i && ad >= 17'h1f800 && ad <= 17'h1fbff);
        sw_req_i <= 1'b1;
        sw_pc_i <= pc;
        sw_addr_i <= ad;
        sw_store_i <= st;
        sw_fetch_i <= fe;
        @(posedge clk_i);
        sw_req_i <= 1'b0;
        #1;
        chk(sw_deny_o, st && !ok);
        chk(sw_grant_o, !st || ok);
        chk(sw_write_o, st && ok && !store_erase_enable_i);
        chk(sw_erase_o, st && ok && store_erase_enable_i);
        @(posedge clk_i);
        #1;
        if (!st) chk(sw_rdata_o, bl && !fe && ad != 17'h1fbff && ad != 17'h1fbfe
            ? 8'hff : ad[7:0] ^ ad[15:8]);
    endtask : sw
    task automatic jt(input logic [1:0] op, input logic [16:0] ad);
        logic sc, dn;
        logic [1:0] k;
        @(posedge clk_i);
        sc = ad == 17'h1fbff || ad == 17'h1fbfe;
        k = 2'h0;
        dn = op == 2'h2 || (op == 2'h1 && !sc && !write_lock_byte_i[ad[16:14]]);
        if (op == 2'h3) begin
            k = sc ? 2'h3 : ((ad >= 17'h1f800 && ad <= 17'h1fbff ? write_lock_byte_i[7]
                : write_lock_byte_i[ad[16:14]]) ? 2'h1 : 2'h0);
            dn = k == 2'h0;
        end
        jt_req_i <= 1'b1;
        jt_op_i <= op;
        jt_addr_i <= ad;
        @(posedge clk_i);
        jt_req_i <= 1'b0;
        #1;
        chk(jt_deny_o, dn);
        chk(jt_erase_kind_o, k);
        chk(jt_grant_o, !dn);
        @(posedge clk_i);
        #1;
        if (op == 2'h0) chk(jt_rdata_o, !sc && !read_lock_byte_i[ad[16:14]]
            ? 8'hff : ad[7:0] ^ ad[15:8]);
        chk(debug_blocked_o, read_lock_byte_i != 8'hff);
    endtask : jt
    initial begin
        repeat (20000) @(posedge clk_i);
        n_fail++;
        summarize();
    end
    initial begin
        void'($urandom(32'h5c7980db));
        do_reset();
        set_lim(8'h40);
        set_lim(8'h20);
        {store_write_enable_i, store_erase_enable_i, flash_modify_enable_i} <= 3'h7;
        sw(17'h00100, 17'h1f900, 1'b1, 1'b0);
        store_erase_enable_i <= 1'b0;
        sw(17'h00100, 17'h1fbfe, 1'b1, 1'b0);
        sw(17'h09000, 17'h00200, 1'b0, 1'b1);
        repeat (60) begin
            @(posedge clk_i);
            {store_write_enable_i, store_erase_enable_i, flash_modify_enable_i} <= 3'($urandom);
            st_r = 1'($urandom);
            sw(17'($urandom), 17'($urandom), st_r, 1'($urandom) & ~st_r);
        end
        do_reset();
        set_lim(8'h00);
        set_lim(8'h10);
        write_lock_byte_i <= 8'h7f;
        jt(2'h1, 17'h1fbfe);
        jt(2'h3, 17'h1f900);
        jt(2'h3, 17'h1fbff);
        repeat (60) begin
            @(posedge clk_i);
            read_lock_byte_i <= 8'($urandom);
            write_lock_byte_i <= 8'($urandom);
            a = 17'($urandom);
            if (a[1:0] == 2'h3) a = 17'h1fbfe | 17'(a[2]);
            else if (a[1:0] == 2'h2) a = 17'h1f800 | 17'(a[9:2]);
            jt(2'($urandom), a);
        end
        summarize();
    end
endmodule : fsag_guard_test
`default_nettype wire
